//--- pkg/ldc_pkg.sv
// Constants and types shared by the line driver direction control block
`default_nettype none
package ldc_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int unsigned NUM_CH       = 8;
    localparam int unsigned SW_BITS      = 8;
    localparam int unsigned NUM_BANKS    = 3;
    localparam int unsigned ADDR_BITS    = 24;
    localparam int unsigned WIN_BITS     = 6;
    localparam int unsigned NORM_TOP     = 8;
    localparam int unsigned EXT_TOP      = 16;
    localparam int unsigned HI_LO        = 16;
    localparam int unsigned HI_TOP       = 21;

    // ****************************************************************
    // Reset and encoded values
    // ****************************************************************
    localparam logic [7:0] TXEN_RESET    = 8'hFF;
    localparam logic       TXEN_ON       = 1'h0;
    localparam logic       TXEN_OFF      = 1'h1;
    localparam logic [1:0] IRQ_TO_INT    = 2'h0;
    localparam logic [1:0] IRQ_TO_NMI    = 2'h1;

    // Multi purpose input index fed by each switch bank
    localparam logic [1:0] BANK1_INPUT   = 2'h3;
    localparam logic [1:0] BANK2_INPUT   = 2'h2;
    localparam logic [1:0] BANK3_INPUT   = 2'h1;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        LDC_MAP_NORMAL   = 2'b00,
        LDC_MAP_EXTENDED = 2'b01,
        LDC_MAP_ENHANCED = 2'b10
    } ldc_map_type;

endpackage : ldc_pkg
`default_nettype wire

//--- pkg/ldc_dec_if.sv
// Address decode request and answer between the top and the decoder
`timescale 1ns/10ps
`default_nettype none
interface ldc_dec_if;
    import ldc_pkg::*;
    logic [ADDR_BITS-1:0] addr;
    logic                 opfetch_n;
    logic [1:0]           mode;
    logic [15:0]          base;
    logic [4:0]           hi_base;
    logic                 hi_use;
    logic                 hit;

    modport top (output addr, opfetch_n, mode, base, hi_base, hi_use, input hit);
    modport dec (input addr, opfetch_n, mode, base, hi_base, hi_use, output hit);
endinterface : ldc_dec_if
`default_nettype wire

//--- design/ldc_addr_decode.sv
// Window decoder for the three address mapping modes
`timescale 1ns/10ps
`default_nettype none
module ldc_addr_decode
    import ldc_pkg::*;
(
    // Decode group
    ldc_dec_if.dec d
);
    // ****************************************************************
    // Compare fields
    // ****************************************************************
    wire logic norm_ok  = d.addr[NORM_TOP-1:WIN_BITS] == d.base[NORM_TOP-1:WIN_BITS];
    wire logic ext_ok   = d.addr[EXT_TOP-1:NORM_TOP] == d.base[EXT_TOP-1:NORM_TOP];
    // Upper bits and fetch cycle only count when the option is fitted
    wire logic hi_ok    = !d.hi_use ||
                          ((d.addr[HI_TOP-1:HI_LO] == d.hi_base) && d.opfetch_n);

    // ****************************************************************
    // Mode select
    // ****************************************************************
    // Bits above a mode's span are ignored, so the window repeats higher up
    always_comb begin
        unique case (d.mode)
            LDC_MAP_NORMAL:   d.hit = norm_ok;
            LDC_MAP_EXTENDED: d.hit = norm_ok && ext_ok;
            LDC_MAP_ENHANCED: d.hit = norm_ok && ext_ok && hi_ok;
            default:          d.hit = 1'b0;
        endcase
    end
endmodule : ldc_addr_decode
`default_nettype wire

//--- design/ldc_line_ctrl.sv
// Line driver direction control, interrupt routing and switch readback
//
// Summary of operation
// - Enable output low turns transmitter on
// - Reset forces enable outputs 7:0 high, any above bit 7 low
// - Two-wire pair direction follows enable level
// - Receiver keeps listening while channel transmits
// - Serial interrupt routed to NMI or INT
// - Software chooses interrupt causes in controller
// - Open-drain interrupts shared, no vector given
// - Three eight-position switch banks readable
// - Banks feed multi purpose inputs 3,2,1
// - Card decodes a 64-byte relocatable window
// - Three mapping modes selectable
// - Normal mode compares address bits 6,7
// - Enhanced mode adds upper bits and fetch
`timescale 1ns/10ps
`default_nettype none
module ldc_line_ctrl
    import ldc_pkg::*;
#(
    parameter int unsigned CH = NUM_CH
)(
    // Clock, reset, enable
    input  wire logic                 CLK,
    input  wire logic                 SRST,
    input  wire logic                 CE,
    // Direction bit writes from the serial controller output port
    input  wire logic [CH-1:0]        TXEN_WR_MASK,
    input  wire logic [CH-1:0]        TXEN_WR_DATA,
    // Transmit enables to the line drivers, active low
    output logic      [CH-1:0]        TX_ENABLE_N_ALL_CHANNELS,
    // Receiver enables, active low, always listening
    output logic      [CH-1:0]        RX_ENABLE_N,
    // Two-wire mode select per channel, and line direction
    input  wire logic [CH-1:0]        TWO_WIRE_MODE,
    output logic      [CH-1:0]        LINE_IS_TX,
    // Interrupt request from the controller and open-drain bus lines
    input  wire logic                 SERIAL_IRQ_N,
    input  wire logic [1:0]           IRQ_ROUTE,
    output logic                      INT_N_OE,
    output logic                      NMI_N_OE,
    output logic                      INT_N_O,
    output logic                      NMI_N_O,
    // Switch banks, pins, ON reads as zero
    input  wire logic [SW_BITS-1:0]   CONFIG_SWITCH_BANK_1,
    input  wire logic [SW_BITS-1:0]   CONFIG_SWITCH_BANK_2,
    input  wire logic [SW_BITS-1:0]   CONFIG_SWITCH_BANK_3,
    input  wire logic [2:0]           BANK_SCAN,
    output logic      [3:1]           MULTI_PURPOSE_INPUT,
    // Host bus address and strap configuration
    input  wire logic [ADDR_BITS-1:0] BUS_ADDR,
    input  wire logic                 BUS_OPFETCH_N,
    input  wire logic                 BUS_IORQ,
    input  wire logic [1:0]           MAP_MODE,
    input  wire logic [15:0]          MAP_BASE,
    input  wire logic [4:0]           MAP_HI_BASE,
    input  wire logic                 MAP_HI_USE,
    output logic                      CARD_SELECT,
    output logic      [WIN_BITS-1:0]  REG_OFFSET
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int unsigned SW_ALL = SW_BITS * NUM_BANKS;
    logic [SW_ALL-1:0] sw_s1_r, sw_s2_r;
    logic              irq_s1_r, irq_s2_r;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sw_s1_r  <= '1;
            sw_s2_r  <= '1;
            irq_s1_r <= 1'b1;
            irq_s2_r <= 1'b1;
        end else if (CE) begin
            sw_s1_r  <= {CONFIG_SWITCH_BANK_3, CONFIG_SWITCH_BANK_2, CONFIG_SWITCH_BANK_1};
            sw_s2_r  <= sw_s1_r;
            irq_s1_r <= SERIAL_IRQ_N;
            irq_s2_r <= irq_s1_r;
        end
    end

    // ****************************************************************
    // Transmit enables
    // ****************************************************************
    // Masked write keeps every channel whose mask bit is clear untouched
    logic [CH-1:0] txen_r;
    wire  logic [CH-1:0] txen_nxt = (txen_r & ~TXEN_WR_MASK)
                                  | (TXEN_WR_DATA & TXEN_WR_MASK);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            txen_r <= CH'(TXEN_RESET);
        end else if (CE) begin
            txen_r <= txen_nxt;
        end
    end

    // Driver pin is the register itself, low means driving
    assign TX_ENABLE_N_ALL_CHANNELS = txen_r;

    // ****************************************************************
    // Enable checks
    // ****************************************************************
    chk_reset_enables_high: assert property (@(posedge CLK)
        $past(SRST)
        |-> TX_ENABLE_N_ALL_CHANNELS == CH'(TXEN_RESET))
        else $error("Enables not high after reset");
    chk_write_next_clock: assert property (@(posedge CLK) disable iff (SRST)
        CE && TXEN_WR_MASK[0]
        |=> TX_ENABLE_N_ALL_CHANNELS[0] == $past(TXEN_WR_DATA[0]))
        else $error("Enable write late");
    chk_top_write_lands: assert property (@(posedge CLK) disable iff (SRST)
        CE && TXEN_WR_MASK[CH-1]
        |=> TX_ENABLE_N_ALL_CHANNELS[CH-1] == $past(TXEN_WR_DATA[CH-1]))
        else $error("Top channel write lost");
    chk_others_kept: assert property (@(posedge CLK) disable iff (SRST)
        CE && !TXEN_WR_MASK[1]
        |=> $stable(TX_ENABLE_N_ALL_CHANNELS[1]))
        else $error("Unwritten channel changed");
    chk_frozen_enables: assert property (@(posedge CLK) disable iff (SRST)
        !CE
        |=> $stable(TX_ENABLE_N_ALL_CHANNELS))
        else $error("Enables moved while frozen");

    // ****************************************************************
    // Direction and receiver
    // ****************************************************************
    // Receiver never gated off so the echo reaches software
    logic [CH-1:0] line_tx_r;
    logic [CH-1:0] rx_en_n_r;
    wire  logic [CH-1:0] line_tx_nxt = TWO_WIRE_MODE & ~txen_nxt;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            line_tx_r <= '0;
            rx_en_n_r <= '0;
        end else if (CE) begin
            line_tx_r <= line_tx_nxt;
            rx_en_n_r <= '0;
        end
    end

    assign LINE_IS_TX  = line_tx_r;
    assign RX_ENABLE_N = rx_en_n_r;

    // ****************************************************************
    // Direction checks
    // ****************************************************************
    chk_rx_listening: assert property (@(posedge CLK) disable iff (SRST)
        ##1 RX_ENABLE_N == '0)
        else $error("Receiver disabled");
    chk_dir_follows: assert property (@(posedge CLK) disable iff (SRST)
        CE ##1 CE
        |-> LINE_IS_TX == (TWO_WIRE_MODE & ~TX_ENABLE_N_ALL_CHANNELS)
            || !$stable(TWO_WIRE_MODE))
        else $error("Direction mismatch");
    chk_four_wire_dir: assert property (@(posedge CLK) disable iff (SRST)
        CE
        |=> (LINE_IS_TX & ~$past(TWO_WIRE_MODE)) == '0)
        else $error("Four-wire channel shown as sending");

    // ****************************************************************
    // Interrupt routing
    // ****************************************************************
    // Open drain: we only pull low, so several cards may share a line
    wire logic irq_act = !irq_s2_r;
    wire logic to_nmi  = IRQ_ROUTE == IRQ_TO_NMI;
    wire logic to_int  = IRQ_ROUTE == IRQ_TO_INT;
    logic int_oe_r, nmi_oe_r;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            int_oe_r <= 1'b0;
            nmi_oe_r <= 1'b0;
        end else if (CE) begin
            int_oe_r <= irq_act && to_int;
            nmi_oe_r <= irq_act && to_nmi;
        end
    end

    assign INT_N_OE = int_oe_r;
    assign NMI_N_OE = nmi_oe_r;
    assign INT_N_O  = 1'b0;
    assign NMI_N_O  = 1'b0;

    // ****************************************************************
    // Interrupt checks
    // ****************************************************************
    // Route codes other than the two lines leave both lines released
    chk_one_irq_line: assert property (@(posedge CLK) disable iff (SRST)
        !(INT_N_OE && NMI_N_OE))
        else $error("Both interrupt lines driven");
    chk_irq_route: assert property (@(posedge CLK) disable iff (SRST)
        CE && !irq_s2_r && IRQ_ROUTE == IRQ_TO_NMI
        |=> NMI_N_OE)
        else $error("NMI not driven");
    chk_irq_int_route: assert property (@(posedge CLK) disable iff (SRST)
        CE && !irq_s2_r && IRQ_ROUTE == IRQ_TO_INT
        |=> INT_N_OE)
        else $error("INT not driven");
    chk_irq_released: assert property (@(posedge CLK) disable iff (SRST)
        CE && irq_s2_r
        |=> !INT_N_OE && !NMI_N_OE)
        else $error("Interrupt line held without request");

    // ****************************************************************
    // Switch readback
    // ****************************************************************
    // One switch position per bank is presented at a time
    logic [3:1] mpi_r;
    wire  logic [SW_BITS-1:0] bank1 = sw_s2_r[SW_BITS-1:0];
    wire  logic [SW_BITS-1:0] bank2 = sw_s2_r[2*SW_BITS-1:SW_BITS];
    wire  logic [SW_BITS-1:0] bank3 = sw_s2_r[SW_ALL-1:2*SW_BITS];
    // Scan select comes from logic on this clock, so it needs no synchroniser
    wire  logic               bank1_bit = bank1[BANK_SCAN];
    wire  logic               bank2_bit = bank2[BANK_SCAN];
    wire  logic               bank3_bit = bank3[BANK_SCAN];

    always_ff @(posedge CLK) begin
        if (SRST) begin
            mpi_r <= '1;
        end else if (CE) begin
            mpi_r[BANK1_INPUT] <= bank1_bit;
            mpi_r[BANK2_INPUT] <= bank2_bit;
            mpi_r[BANK3_INPUT] <= bank3_bit;
        end
    end

    assign MULTI_PURPOSE_INPUT = mpi_r;

    // ****************************************************************
    // Switch checks
    // ****************************************************************
    chk_bank1_input: assert property (@(posedge CLK) disable iff (SRST)
        CE
        |=> MULTI_PURPOSE_INPUT[BANK1_INPUT] == $past(bank1_bit))
        else $error("First bank on wrong input");
    chk_bank2_input: assert property (@(posedge CLK) disable iff (SRST)
        CE
        |=> MULTI_PURPOSE_INPUT[BANK2_INPUT] == $past(bank2_bit))
        else $error("Second bank on wrong input");
    chk_bank3_input: assert property (@(posedge CLK) disable iff (SRST)
        CE
        |=> MULTI_PURPOSE_INPUT[BANK3_INPUT] == $past(bank3_bit))
        else $error("Third bank on wrong input");

    // ****************************************************************
    // Window decode
    // ****************************************************************
    ldc_dec_if dif ();
    assign dif.addr      = BUS_ADDR;
    assign dif.opfetch_n = BUS_OPFETCH_N;
    assign dif.mode      = MAP_MODE;
    assign dif.base      = MAP_BASE;
    assign dif.hi_base   = MAP_HI_BASE;
    assign dif.hi_use    = MAP_HI_USE;

    ldc_addr_decode u_dec (
        .d (dif.dec)
    );

    logic                sel_r;
    logic [WIN_BITS-1:0] off_r;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sel_r <= 1'b0;
            off_r <= '0;
        end else if (CE) begin
            sel_r <= BUS_IORQ && dif.hit;
            off_r <= BUS_ADDR[WIN_BITS-1:0];
        end
    end

    assign CARD_SELECT = sel_r;
    assign REG_OFFSET  = off_r;

    // ****************************************************************
    // Decode checks
    // ****************************************************************
    chk_idle_no_select: assert property (@(posedge CLK) disable iff (SRST)
        CE && !BUS_IORQ
        |=> !CARD_SELECT)
        else $error("Select without bus cycle");
    chk_offset_follows: assert property (@(posedge CLK) disable iff (SRST)
        CE
        |=> REG_OFFSET == $past(BUS_ADDR[WIN_BITS-1:0]))
        else $error("Offset not taken");
    chk_window_sel: assert property (@(posedge CLK) disable iff (SRST)
        CE && BUS_IORQ && MAP_MODE == LDC_MAP_NORMAL
        && BUS_ADDR[NORM_TOP-1:WIN_BITS] != MAP_BASE[NORM_TOP-1:WIN_BITS]
        |=> !CARD_SELECT)
        else $error("Select outside window");
    chk_window_hit: assert property (@(posedge CLK) disable iff (SRST)
        CE && BUS_IORQ && MAP_MODE == LDC_MAP_NORMAL
        && BUS_ADDR[NORM_TOP-1:WIN_BITS] == MAP_BASE[NORM_TOP-1:WIN_BITS]
        |=> CARD_SELECT)
        else $error("Window not selected");
    chk_no_map_hit: assert property (@(posedge CLK) disable iff (SRST)
        CE && !(MAP_MODE inside {LDC_MAP_NORMAL, LDC_MAP_EXTENDED, LDC_MAP_ENHANCED})
        |=> !CARD_SELECT)
        else $error("Select in unused mapping mode");
    chk_fetch_excluded: assert property (@(posedge CLK) disable iff (SRST)
        CE && MAP_MODE == LDC_MAP_ENHANCED && MAP_HI_USE && !BUS_OPFETCH_N
        |=> !CARD_SELECT)
        else $error("Select on fetch cycle");
endmodule : ldc_line_ctrl
`default_nettype wire

//--- verification/ldc_bus_line_model.sv
// Shared open-drain interrupt line of the backplane, pulled up
`timescale 1ns/10ps
`default_nettype none
module ldc_bus_line_model (
    // Card under test and one other card
    input  wire logic card_oe,
    input  wire logic card_o,
    input  wire logic other_oe,
    // Resolved level seen by all cards
    output wire logic line_n
);
    // Any card may pull at once; no vector, so the host must poll every card
    assign line_n = !((card_oe && !card_o) || other_oe);
endmodule : ldc_bus_line_model
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the line driver direction control block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ldc_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk, srst, ce, irq_n, iorq, opf_n, hi_use, other_oe;
    logic [7:0]  wmask, wdata, twm, txen, rxen, ltx, b1, b2, b3, exp_en;
    logic [1:0]  route, mode;
    logic [2:0]  scan;
    logic [3:1]  multi_purpose_input;
    logic [23:0] addr;
    logic [15:0] base;
    logic [4:0]  hib;
    logic [5:0]  offs;
    logic        int_oe, nmi_oe, int_o, nmi_o, csel, int_line, nmi_line;
    int          errors, checks;

    ldc_line_ctrl ldc_line_ctrl_inst (.CLK(clk), .SRST(srst), .CE(ce),
        .TXEN_WR_MASK(wmask), .TXEN_WR_DATA(wdata), .TX_ENABLE_N_ALL_CHANNELS(txen),
        .RX_ENABLE_N(rxen), .TWO_WIRE_MODE(twm), .LINE_IS_TX(ltx),
        .SERIAL_IRQ_N(irq_n), .IRQ_ROUTE(route), .INT_N_OE(int_oe), .NMI_N_OE(nmi_oe),
        .INT_N_O(int_o), .NMI_N_O(nmi_o), .CONFIG_SWITCH_BANK_1(b1),
        .CONFIG_SWITCH_BANK_2(b2), .CONFIG_SWITCH_BANK_3(b3), .BANK_SCAN(scan),
        .MULTI_PURPOSE_INPUT(multi_purpose_input), .BUS_ADDR(addr), .BUS_OPFETCH_N(opf_n),
        .BUS_IORQ(iorq), .MAP_MODE(mode), .MAP_BASE(base), .MAP_HI_BASE(hib),
        .MAP_HI_USE(hi_use), .CARD_SELECT(csel), .REG_OFFSET(offs));
    ldc_bus_line_model int_line_inst (.card_oe(int_oe), .card_o(int_o),
        .other_oe(other_oe), .line_n(int_line));
    ldc_bus_line_model nmi_line_inst (.card_oe(nmi_oe), .card_o(nmi_o),
        .other_oe(1'b0), .line_n(nmi_line));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic cmp_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_bits

    // Mask is dropped after one edge so a write is never repeated by accident
    task automatic wr_en(input logic [7:0] m, input logic [7:0] d);
        @(posedge clk);
        wmask <= m;
        wdata <= d;
        @(posedge clk);
        wmask <= 8'h00;
        #1;
    endtask : wr_en

    task automatic dec(input logic [23:0] a, input logic hit, input logic [5:0] off);
        @(posedge clk);
        addr <= a;
        iorq <= 1'b1;
        step(1);
        cmp_bits("card select", {7'h00, hit}, {7'h00, csel});
        cmp_bits("reg offset", {2'h0, off}, {2'h0, offs});
    endtask : dec

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        {srst, ce, irq_n, opf_n} = 4'hF;
        {iorq, hi_use, other_oe} = 3'h0;
        {wmask, wdata, twm, b1, b2, b3} = 48'h0;
        {route, mode, scan, addr, base, hib} = 52'h0;
        errors = 0;
        checks = 0;
        step(12);
        cmp_bits("enables in reset", TXEN_RESET, txen);
        cmp_bits("mpi in reset", 8'h07, {5'h00, multi_purpose_input});
        @(posedge clk);
        srst <= 1'b0;
        twm <= 8'hFF;
        exp_en = TXEN_RESET;
        for (int i = 0; i < 8; i++) begin
            exp_en = exp_en & ~(8'h01 << i);
            wr_en(8'h01 << i, 8'h00);
            cmp_bits("tx enable", exp_en, txen);
            cmp_bits("line dir", ~exp_en, ltx);
            cmp_bits("rx enable", 8'h00, rxen);
        end
        wr_en(8'hF0, 8'hA0);
        cmp_bits("tx enable", 8'hA0, txen);
        @(posedge clk);
        twm <= 8'h0F;
        step(1);
        cmp_bits("line dir", 8'h0F, ltx);
        @(posedge clk);
        ce <= 1'b0;
        wr_en(8'hFF, 8'hFF);
        cmp_bits("frozen enable", 8'hA0, txen);
        ce <= 1'b1;
        wr_en(8'h0F, 8'h0F);
        cmp_bits("tx enable", 8'hAF, txen);
        @(posedge clk);
        srst <= 1'b1;
        step(1);
        cmp_bits("enables after reset", TXEN_RESET, txen);
        srst <= 1'b0;
        $display("test enables done");

        mode <= LDC_MAP_NORMAL;
        base <= 16'h0080;
        dec(24'h000080, 1'b1, 6'h00);
        dec(24'h0000BF, 1'b1, 6'h3F);
        dec(24'h0000C0, 1'b0, 6'h00);
        dec(24'h000180, 1'b1, 6'h00);
        mode <= LDC_MAP_EXTENDED;
        base <= 16'h4000;
        dec(24'h004000, 1'b1, 6'h00);
        dec(24'h014000, 1'b1, 6'h00);
        dec(24'h004100, 1'b0, 6'h00);
        mode <= LDC_MAP_ENHANCED;
        hi_use <= 1'b1;
        hib <= 5'h1F;
        dec(24'h1F4000, 1'b1, 6'h00);
        dec(24'hFF4000, 1'b1, 6'h00);
        dec(24'h1E4000, 1'b0, 6'h00);
        opf_n <= 1'b0;
        dec(24'h1F4000, 1'b0, 6'h00);
        mode <= 2'h3;
        dec(24'h004000, 1'b0, 6'h00);
        @(posedge clk);
        {mode, hi_use, opf_n, iorq} <= {LDC_MAP_ENHANCED, 3'b010};
        step(2);
        cmp_bits("idle select", 8'h00, {7'h00, csel});
        $display("test decode done");

        for (int r = 0; r < 3; r++) begin
            @(posedge clk);
            route <= 2'(r);
            irq_n <= 1'b0;
            step(4);
            cmp_bits("int drive", {7'h00, r == 0}, {7'h00, int_oe});
            cmp_bits("nmi drive", {7'h00, r == 1}, {7'h00, nmi_oe});
            cmp_bits("int line", {7'h00, r != 0}, {7'h00, int_line});
            cmp_bits("nmi line", {7'h00, r != 1}, {7'h00, nmi_line});
            irq_n <= 1'b1;
            step(4);
            cmp_bits("drives freed", 8'h00, {6'h00, int_oe, nmi_oe});
        end
        other_oe <= 1'b1;
        step(1);
        cmp_bits("shared line", 8'h00, {7'h00, int_line});
        $display("test interrupts done");

        b1 <= 8'hA5;
        b2 <= 8'h3C;
        b3 <= 8'h81;
        step(4);
        for (int k = 0; k < 8; k++) begin
            scan <= 3'(k);
            step(1);
            cmp_bits("switch input", {5'h00, b1[k], b2[k], b3[k]}, {5'h00, multi_purpose_input});
        end
        $display("test switches done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
